// ===== core/absd_pkg.sv
package absd_pkg;
    // conversion clock: 1 MHz, design clock 125 MHz
    localparam int unsigned ABSD_CLK_MHZ = 125;
    localparam int unsigned ABSD_CONV_MHZ = 1;
    // delay from request to decoder enable, in microseconds
    localparam int unsigned ABSD_DELAY_US = 2;
    // conversion clock edges that make up the delay
    localparam logic [1:0] ABSD_DELAY_EDGES = 2'(ABSD_DELAY_US * ABSD_CONV_MHZ);
    // conversion clock divider in the controller end
    localparam int unsigned ABSD_CONV_HALF = ABSD_CLK_MHZ / (2 * ABSD_CONV_MHZ);
    localparam logic [6:0] ABSD_CONV_HALF_M1 = 7'(ABSD_CONV_HALF - 1);
    // analog assembly select codes
    localparam logic [1:0] ABSD_SEL_RF = 2'h0;
    localparam logic [1:0] ABSD_SEL_FC = 2'h1;
    localparam logic [1:0] ABSD_SEL_IF = 2'h2;
    localparam logic [1:0] ABSD_SEL_LOG = 2'h3;
    // counter load strobes are active high on the second local decoder
    localparam logic [7:0] ABSD_DEC2_HIGH_MASK = 8'h30;
    localparam logic [7:0] ABSD_ALL_HIGH = 8'hff;
    localparam logic [7:0] ABSD_ONE = 8'h01;
endpackage : absd_pkg

// ===== core/absd_bus_if.sv
`timescale 1ns/1ps
interface absd_bus_if;
    logic analog_bus_request;
    logic [1:0] analog_sel;
    logic conversion_clock_1mhz;
    logic local_access;
    logic [3:0] local_addr;
    logic local_bank;
    logic [7:0] addr;
    logic [7:0] data;
    modport device (
        input analog_bus_request, analog_sel, conversion_clock_1mhz,
        input local_access, local_addr, local_bank, addr, data
    );
    modport controller (
        output analog_bus_request, analog_sel, conversion_clock_1mhz,
        output local_access, local_addr, local_bank, addr, data
    );
endinterface : absd_bus_if

// ===== core/absd_controller.sv
`timescale 1ns/1ps
module absd_controller
    import absd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // user commands: one-cycle pulses, taken when o_ready is high
    input wire logic i_analog_wr,
    input wire logic [1:0] i_analog_sel,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_data,
    input wire logic i_local_wr,
    input wire logic i_local_bank,
    input wire logic [3:0] i_local_addr,
    input wire logic [3:0] i_hold_us,
    output logic o_ready,
    // bus side
    absd_bus_if.controller bus
);
    import absd_pkg::*;

    typedef enum logic [2:0] {
        ABSD_C_IDLE = 3'b001,
        ABSD_C_ANA = 3'b010,
        ABSD_C_LOC = 3'b100
    } absd_cst_t;

    typedef struct packed {
        absd_cst_t st;
        logic [6:0] div;
        logic conv;
        logic [3:0] us_left;
        logic [1:0] sel;
        logic [7:0] addr;
        logic [7:0] data;
        logic bank;
        logic [3:0] laddr;
    } absd_cstate_t;

    absd_cstate_t r;
    absd_cstate_t next_r;
    logic conv_rise;

    always_comb begin
        next_r = r;
        conv_rise = 1'b0;
        // free-running 1 MHz conversion clock from the system clock
        if (r.div == ABSD_CONV_HALF_M1) begin
            next_r.div = '0;
            next_r.conv = ~r.conv;
            conv_rise = ~r.conv;
        end else begin
            next_r.div = r.div + 7'h01;
        end
        unique case (r.st)
            ABSD_C_IDLE: begin
                if (i_analog_wr) begin
                    // a settings change is written as one analog access
                    next_r.st = ABSD_C_ANA;
                    next_r.sel = i_analog_sel;
                    next_r.addr = i_addr;
                    next_r.data = i_data;
                    next_r.us_left = i_hold_us + 4'(ABSD_DELAY_EDGES) + 4'h1;
                end else if (i_local_wr) begin
                    next_r.st = ABSD_C_LOC;
                    next_r.bank = i_local_bank;
                    next_r.laddr = i_local_addr;
                    next_r.us_left = i_hold_us;
                end
            end
            ABSD_C_ANA, ABSD_C_LOC: begin
                // access length measured in conversion clock periods
                if (conv_rise) begin
                    if (r.us_left == '0) begin
                        next_r.st = ABSD_C_IDLE;
                    end else begin
                        next_r.us_left = r.us_left - 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '{st: ABSD_C_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign o_ready = (r.st == ABSD_C_IDLE);
    assign bus.analog_bus_request = (r.st == ABSD_C_ANA);
    assign bus.local_access = (r.st == ABSD_C_LOC);
    assign bus.analog_sel = r.sel;
    assign bus.conversion_clock_1mhz = r.conv;
    assign bus.addr = r.addr;
    assign bus.data = r.data;
    assign bus.local_bank = r.bank;
    assign bus.local_addr = r.laddr;
endmodule : absd_controller

// ===== core/absd_device.sv
`timescale 1ns/1ps
// Function
// - decoder enable goes low 1 to 2 us after request
// - delay counted on the 1 MHz conversion clock
// - four strobes: RF, freq-control, IF, log-amp
// - separate qualifier with the freq-control strobe
// - reference selection writes pulse the RF strobe
// - attenuation writes pulse the freq-control strobe
// - reference level writes pulse the IF strobe
// - scale toggle writes pulse the log-amp strobe
// - buffer 8-bit address and data unchanged
// - first local decoder on address bits 1-3
// - second local decoder on bits 0-2, loads high
module absd_device
    import absd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bus side
    absd_bus_if.device bus,
    // analog assembly strobes
    output logic o_rf_assembly_strobe_n,
    output logic o_freq_ctl_strobe_n,
    output logic o_freq_ctl_qualifier_n,
    output logic o_if_assembly_strobe_n,
    output logic o_log_amp_strobe_n,
    output logic o_decoder_enable_n,
    // buffered cable bus
    output logic [7:0] o_cable_addr,
    output logic [7:0] o_cable_data,
    // first local decoder
    output logic o_keypad_scan_strobe_n,
    output logic o_upper_converter_strobe_n,
    output logic o_converter1_strobe_n,
    output logic o_converter2_strobe_n,
    output logic o_converter3_strobe_n,
    output logic o_interval_counter_strobe_n,
    output logic o_sampler_reg1_strobe_n,
    // second local decoder
    output logic o_keypad_sense_strobe_n,
    output logic o_irq_priority_strobe_n,
    output logic o_sampler_data_strobe_n,
    output logic o_converter_data_strobe_n,
    output logic o_count_load0_strobe,
    output logic o_count_load1_strobe,
    output logic o_knob_read_strobe_n,
    output logic o_sampler_reg0_strobe_n
);
    import absd_pkg::*;

    typedef enum logic [2:0] {
        ABSD_D_IDLE = 3'b001,
        ABSD_D_WAIT = 3'b010,
        ABSD_D_ON = 3'b100
    } absd_dst_t;

    // whole device state, registered as one word
    typedef struct packed {
        absd_dst_t st;
        logic conv_meta;
        logic conv_sync;
        logic conv_prev;
        logic [1:0] edges;
        logic [3:0] ana_n;
        logic qual_n;
        logic [7:0] dec1_n;
        logic [7:0] dec2;
        logic [7:0] addr;
        logic [7:0] data;
    } absd_dstate_t;

    absd_dstate_t r;
    absd_dstate_t next_r;
    logic conv_rise;
    logic [3:0] ana_code;
    logic [1:0] edges_inc;
    logic loc1_en;
    logic loc2_en;
    logic [7:0] dec1_hot;
    logic [7:0] dec2_hot;

    // idle levels: every strobe inactive, counter loads low, cable buses cleared
    localparam absd_dstate_t ABSD_D_RESET = '{
        st: ABSD_D_IDLE,
        conv_meta: 1'b0,
        conv_sync: 1'b0,
        conv_prev: 1'b0,
        edges: 2'h0,
        ana_n: 4'hf,
        qual_n: 1'b1,
        dec1_n: ABSD_ALL_HIGH,
        dec2: ~ABSD_DEC2_HIGH_MASK,
        addr: 8'h00,
        data: 8'h00
    };

    // one-hot decode of a 3-bit select, gated by an access
    function automatic logic [7:0] absd_decode(input logic [2:0] code, input logic en);
        absd_decode = 8'h00;
        if (en) begin
            absd_decode = ABSD_ONE << code;
        end
    endfunction : absd_decode

    // one-hot select of the four analog assembly strobes, gated by the decoder enable
    function automatic logic [3:0] absd_ana_decode(input logic [1:0] sel, input logic en);
        absd_ana_decode = 4'h0;
        if (en) begin
            absd_ana_decode = 4'(ABSD_ONE << sel);
        end
    endfunction : absd_ana_decode

    always_comb begin
        next_r = r;
        // two-flop sync keeps the conversion clock edge detector off the first stage
        next_r.conv_meta = bus.conversion_clock_1mhz;
        next_r.conv_sync = r.conv_meta;
        next_r.conv_prev = r.conv_sync;
        conv_rise = r.conv_sync & ~r.conv_prev;
        edges_inc = r.edges + 2'h1;
        ana_code = '0;
        unique case (r.st)
            ABSD_D_IDLE: begin
                // counting restarts on every new request
                next_r.edges = '0;
                if (bus.analog_bus_request) begin
                    next_r.st = ABSD_D_WAIT;
                end
            end
            ABSD_D_WAIT: begin
                if (!bus.analog_bus_request) begin
                    next_r.st = ABSD_D_IDLE;
                end else if (conv_rise) begin
                    // a stopped conversion clock never opens the decoder
                    next_r.edges = edges_inc;
                    if (edges_inc == ABSD_DELAY_EDGES) begin
                        next_r.st = ABSD_D_ON;
                    end
                end
            end
            ABSD_D_ON: begin
                // strobe stands until the request drops
                if (!bus.analog_bus_request) begin
                    next_r.st = ABSD_D_IDLE;
                end
            end
        endcase
        // strobes follow the enabled decoder
        ana_code = absd_ana_decode(bus.analog_sel, next_r.st == ABSD_D_ON);
        next_r.ana_n = ~ana_code;
        // qualifier follows the freq-control strobe cycle for cycle
        next_r.qual_n = ~ana_code[ABSD_SEL_FC];
        // cable buffers pass levels straight through, one register of delay
        next_r.addr = bus.addr;
        next_r.data = bus.data;
        // banks share the access strobe so only one decoder fires
        loc1_en = bus.local_access & ~bus.local_bank;
        loc2_en = bus.local_access & bus.local_bank;
        // first decoder reads bits 3..1, bit 0 matters to the second bank only
        dec1_hot = absd_decode(bus.local_addr[3:1], loc1_en);
        dec2_hot = absd_decode(bus.local_addr[2:0], loc2_en);
        next_r.dec1_n = ~dec1_hot;
        // counter loads keep their active-high sense, the rest are inverted
        next_r.dec2 = dec2_hot ^ ~ABSD_DEC2_HIGH_MASK;
    end

    // asynchronous clear to the idle levels above
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= ABSD_D_RESET;
        end else begin
            r <= next_r;
        end
    end

    // analog assembly strobes and their enable, all from registered state
    assign o_decoder_enable_n = ~(r.st == ABSD_D_ON);
    assign o_rf_assembly_strobe_n = r.ana_n[ABSD_SEL_RF];
    assign o_freq_ctl_strobe_n = r.ana_n[ABSD_SEL_FC];
    assign o_if_assembly_strobe_n = r.ana_n[ABSD_SEL_IF];
    assign o_log_amp_strobe_n = r.ana_n[ABSD_SEL_LOG];
    assign o_freq_ctl_qualifier_n = r.qual_n;

    // cable buffers
    assign o_cable_addr = r.addr;
    assign o_cable_data = r.data;

    // first local decoder, active low
    assign o_keypad_scan_strobe_n = r.dec1_n[0];
    assign o_upper_converter_strobe_n = r.dec1_n[1];
    assign o_converter1_strobe_n = r.dec1_n[2];
    assign o_converter2_strobe_n = r.dec1_n[3];
    assign o_converter3_strobe_n = r.dec1_n[4];
    // code 5 of the first decoder is unused and has no pin
    assign o_interval_counter_strobe_n = r.dec1_n[6];
    assign o_sampler_reg1_strobe_n = r.dec1_n[7];

    // second local decoder, counter loads active high
    assign o_keypad_sense_strobe_n = r.dec2[0];
    assign o_irq_priority_strobe_n = r.dec2[1];
    assign o_sampler_data_strobe_n = r.dec2[2];
    assign o_converter_data_strobe_n = r.dec2[3];
    assign o_count_load0_strobe = r.dec2[4];
    assign o_count_load1_strobe = r.dec2[5];
    assign o_knob_read_strobe_n = r.dec2[6];
    assign o_sampler_reg0_strobe_n = r.dec2[7];
endmodule : absd_device

// ===== tb/absd_monitor.sv
`timescale 1ns/1ps
module absd_monitor
    import absd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // bus
    input wire logic analog_bus_request,
    input wire logic [1:0] analog_sel,
    input wire logic conversion_clock_1mhz,
    input wire logic local_access,
    input wire logic [3:0] local_addr,
    input wire logic local_bank,
    input wire logic [7:0] addr,
    input wire logic [7:0] data,
    // device outputs
    input wire logic o_decoder_enable_n,
    input wire logic o_rf_assembly_strobe_n,
    input wire logic o_freq_ctl_strobe_n,
    input wire logic o_freq_ctl_qualifier_n,
    input wire logic o_if_assembly_strobe_n,
    input wire logic o_log_amp_strobe_n,
    input wire logic [7:0] o_cable_addr,
    input wire logic [7:0] o_cable_data,
    input wire logic o_keypad_scan_strobe_n,
    input wire logic o_count_load0_strobe
);
    typedef struct packed {
        logic conv_q;
        logic [1:0] rises;
        logic [7:0] since;
    } absd_mon_t;
    absd_mon_t st, next_st;
    logic [3:0] ana;
    assign ana = {o_log_amp_strobe_n, o_if_assembly_strobe_n, o_freq_ctl_strobe_n,
        o_rf_assembly_strobe_n};
    // raw clock edges are seen before the design's synchronised ones, so counts run ahead, save a raw edge one cycle before the request, which only the design counts
    always_comb begin
        next_st = st;
        next_st.conv_q = conversion_clock_1mhz;
        next_st.rises = 2'h0;
        next_st.since = 8'h00;
        if (analog_bus_request) begin
            next_st.rises = st.rises + {1'b0, conversion_clock_1mhz && !st.conv_q && !st.rises[1]};
            next_st.since = st.since + {7'h00, st.since != 8'hff};
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) st <= '0;
        else st <= next_st;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_req_rise;
        $rose(analog_bus_request);
    endsequence
    sequence s_enable_fall;
        $fell(o_decoder_enable_n);
    endsequence
    AST_ENABLE_DELAY: assert property (s_req_rise |-> ##[120:260] s_enable_fall)
        else $error("decoder enable not delayed as expected");
    AST_NOT_EARLY: assert property (!o_decoder_enable_n && analog_bus_request |-> st.since >= 8'h78)
        else $error("decoder enable too early");
    AST_CONV_CLOCKED: assert property (s_enable_fall |-> st.rises != 2'h0)
        else $error("decoder enable without conversion clock edge");
    AST_STROBE_SEL: assert property (!o_decoder_enable_n |-> ana == ~(4'h1 << $past(analog_sel)))
        else $error("wrong assembly strobe");
    AST_QUALIFIER: assert property (o_freq_ctl_qualifier_n == o_freq_ctl_strobe_n)
        else $error("qualifier differs from strobe");
    AST_RELEASE: assert property ($fell(analog_bus_request) |=> o_decoder_enable_n && ana == 4'hf)
        else $error("strobe outlives request");
    AST_CABLE: assert property (o_cable_addr == $past(addr) && o_cable_data == $past(data))
        else $error("cable bus differs");
    AST_DEC1_SCAN: assert property (local_access && !local_bank && local_addr[3:1] == 3'h0 |=> !o_keypad_scan_strobe_n)
        else $error("scan strobe missing");
    AST_DEC2_LOAD: assert property (local_access && local_bank && local_addr[2:0] == 3'h4 |=> o_count_load0_strobe)
        else $error("load strobe missing");
    AST_LOCAL_IDLE: assert property (!local_access && !$past(local_access) |-> o_keypad_scan_strobe_n && !o_count_load0_strobe)
        else $error("local strobe without access");
endmodule : absd_monitor

// ===== tb/analog_bus_strobe_decoder_bench.sv
`timescale 1ns/1ps
module analog_bus_strobe_decoder_bench;
    import absd_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_analog_wr = 1'b0;
    logic [1:0] i_analog_sel = 2'h0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_data = 8'h00;
    logic i_local_wr = 1'b0;
    logic i_local_bank = 1'b0;
    logic [3:0] i_local_addr = 4'h0;
    logic o_ready, o_decoder_enable_n, o_rf_assembly_strobe_n, o_freq_ctl_strobe_n;
    logic o_freq_ctl_qualifier_n, o_if_assembly_strobe_n, o_log_amp_strobe_n;
    logic [7:0] o_cable_addr, o_cable_data;
    logic o_keypad_scan_strobe_n, o_upper_converter_strobe_n, o_converter1_strobe_n;
    logic o_converter2_strobe_n, o_converter3_strobe_n, o_interval_counter_strobe_n;
    logic o_sampler_reg1_strobe_n, o_keypad_sense_strobe_n, o_irq_priority_strobe_n;
    logic o_sampler_data_strobe_n, o_converter_data_strobe_n, o_count_load0_strobe;
    logic o_count_load1_strobe, o_knob_read_strobe_n, o_sampler_reg0_strobe_n;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    wire logic [3:0] ana = {o_log_amp_strobe_n, o_if_assembly_strobe_n, o_freq_ctl_strobe_n,
        o_rf_assembly_strobe_n};
    // code 5 of the first decoder has no pin; a fixed high stands in its place
    wire logic [7:0] dec1 = {o_sampler_reg1_strobe_n, o_interval_counter_strobe_n, 1'b1,
        o_converter3_strobe_n, o_converter2_strobe_n, o_converter1_strobe_n,
        o_upper_converter_strobe_n, o_keypad_scan_strobe_n};
    wire logic [7:0] dec2 = ABSD_DEC2_HIGH_MASK ^ {o_sampler_reg0_strobe_n, o_knob_read_strobe_n,
        o_count_load1_strobe, o_count_load0_strobe, o_converter_data_strobe_n,
        o_sampler_data_strobe_n, o_irq_priority_strobe_n, o_keypad_sense_strobe_n};
    absd_bus_if bus ();
    absd_controller absd_controller_inst (.i_clk, .i_rst_n, .i_analog_wr, .i_analog_sel,
        .i_addr, .i_data, .i_local_wr, .i_local_bank, .i_local_addr, .i_hold_us(4'h1),
        .o_ready, .bus(bus.controller));
    absd_device absd_device_inst (.i_clk, .i_rst_n, .bus(bus.device), .o_rf_assembly_strobe_n,
        .o_freq_ctl_strobe_n, .o_freq_ctl_qualifier_n, .o_if_assembly_strobe_n,
        .o_log_amp_strobe_n, .o_decoder_enable_n, .o_cable_addr, .o_cable_data,
        .o_keypad_scan_strobe_n, .o_upper_converter_strobe_n, .o_converter1_strobe_n,
        .o_converter2_strobe_n, .o_converter3_strobe_n, .o_interval_counter_strobe_n,
        .o_sampler_reg1_strobe_n, .o_keypad_sense_strobe_n, .o_irq_priority_strobe_n,
        .o_sampler_data_strobe_n, .o_converter_data_strobe_n, .o_count_load0_strobe,
        .o_count_load1_strobe, .o_knob_read_strobe_n, .o_sampler_reg0_strobe_n);
    absd_monitor absd_monitor_inst (.i_clk, .i_rst_n,
        .analog_bus_request(bus.analog_bus_request), .analog_sel(bus.analog_sel),
        .conversion_clock_1mhz(bus.conversion_clock_1mhz), .local_access(bus.local_access),
        .local_addr(bus.local_addr), .local_bank(bus.local_bank), .addr(bus.addr),
        .data(bus.data), .o_decoder_enable_n, .o_rf_assembly_strobe_n, .o_freq_ctl_strobe_n,
        .o_freq_ctl_qualifier_n, .o_if_assembly_strobe_n, .o_log_amp_strobe_n, .o_cable_addr,
        .o_cable_data, .o_keypad_scan_strobe_n, .o_count_load0_strobe);
    always #4 i_clk = ~i_clk;
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask : tick
    task automatic wait_ready();
        for (int n = 0; n < 1000 && o_ready !== 1'b1; n++) tick();
    endtask : wait_ready
    task automatic analog_write(input logic [1:0] sel, input logic [7:0] a);
        int n;
        wait_ready();
        i_analog_wr = 1'b1;
        i_analog_sel = sel;
        i_addr = a;
        i_data = ~a;
        tick();
        i_analog_wr = 1'b0;
        for (n = 0; n < 400 && o_decoder_enable_n !== 1'b0; n++) tick();
        check("delay", 8'h01, {7'h00, n >= 120 && n <= 262});
        check("strobes", {4'hf, ~(4'h1 << sel)}, {4'hf, ana});
        check("qualifier", {7'h00, sel != ABSD_SEL_FC}, {7'h00, o_freq_ctl_qualifier_n});
        check("cable_addr", a, o_cable_addr);
        check("cable_data", ~a, o_cable_data);
        for (n = 0; n < 1000 && o_decoder_enable_n !== 1'b1; n++) tick();
        check("release", 8'h0f, {4'h0, ana});
        $display("analog write done, select %0d", sel);
    endtask : analog_write
    task automatic local_write(input logic bank, input logic [2:0] c);
        wait_ready();
        i_local_wr = 1'b1;
        i_local_bank = bank;
        // the unused address bit is set so a decoder reading the wrong bits shows up
        i_local_addr = bank ? {1'b1, c} : {c, 1'b1};
        tick();
        i_local_wr = 1'b0;
        tick();
        check("dec1", bank ? 8'hff : ~(8'h01 << c) | 8'h20, dec1);
        check("dec2", bank ? ~(8'h01 << c) : 8'hff, dec2);
        tick();
        $display("local write done, bank %0d code %0d", bank, c);
    endtask : local_write
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        tick();
        analog_write(ABSD_SEL_RF, 8'hff);
        analog_write(ABSD_SEL_FC, 8'h00);
        analog_write(ABSD_SEL_IF, 8'ha5);
        analog_write(ABSD_SEL_LOG, 8'h3c);
        for (int c = 0; c < 8; c++) begin
            local_write(1'b0, 3'(c));
            local_write(1'b1, 3'(c));
        end
        $display("local decoder tests done");
        summarize();
    end
endmodule : analog_bus_strobe_decoder_bench
